// ===== design/i2c_stop_wait_defs.vh
// Constants for the stop, wait and interrupt-timing block
`ifndef I2C_STOP_WAIT_DEFS_VH
`define I2C_STOP_WAIT_DEFS_VH

// Clock period of clk_sys in ns
`define SWC_CLK_PERIOD_NS 40
// Least time each stop phase (SDA low, SCL high) is held, in ns
`define SWC_STOP_HOLD_NS 4000
// Least time rounds up to whole cycles
`define SWC_STOP_HOLD_CYC ((`SWC_STOP_HOLD_NS + `SWC_CLK_PERIOD_NS - 1) / `SWC_CLK_PERIOD_NS)
// Half period of the master serial clock, in cycles
`define SWC_SCL_HALF_CYC 50

// Falling-edge numbers within a byte
`define SWC_EDGE_8 4'h8
`define SWC_EDGE_9 4'h9

// Upper address nibbles that mark an extension code
`define SWC_EXT_LOW 4'h0
`define SWC_EXT_HIGH 4'hF

// Reset values
`define SWC_RST_BYTE 8'hFF
`define SWC_RST_CNT 4'h0

`endif

// ===== design/line_sync.v
// Two-flop synchroniser with edge pulses for one bus line
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  input wire clk_sys,
  input wire reset_n,
  input wire line_in,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_r;
  reg sync_r;
  reg prev_r;

  // Lines idle high on an open-drain bus
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= line_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule // line_sync
`default_nettype wire

// ===== design/bus_condition.v
// Start and stop condition detector on synchronised bus lines
`timescale 1ns/1ps
`default_nettype none
module bus_condition (
  input wire scl_level,
  input wire sda_rise,
  input wire sda_fall,
  output wire start_seen,
  output wire stop_seen
);
  // SDA moving while SCL is high marks a condition
  assign start_seen = scl_level & sda_fall;
  assign stop_seen = scl_level & sda_rise;
endmodule // bus_condition
`default_nettype wire

// ===== design/i2c_stop_wait_control.v
// Stop generation and detection, wait control and interrupt timing
`timescale 1ns/1ps
`default_nettype none
`include "i2c_stop_wait_defs.vh"

module i2c_stop_wait_control #(
  parameter [15:0] STOP_HOLD_CYC = `SWC_STOP_HOLD_CYC,
  parameter [15:0] SCL_HALF_CYC = `SWC_SCL_HALF_CYC
) (
  input wire clk_sys,
  input wire reset_n,
  input wire serial_clock_pin_in,
  output reg serial_clock_pin_out,
  output reg serial_clock_pin_oe,
  input wire serial_data_pin_in,
  output reg serial_data_pin_out,
  output reg serial_data_pin_oe,
  input wire controller_enable_bit,
  input wire master_mode,
  input wire transmit_mode,
  input wire stop_request_bit,
  input wire start_request_bit,
  input wire wait_release_bit,
  input wire communication_exit_bit,
  input wire wakeup_mode_bit,
  input wire stop_interrupt_enable,
  input wire wait_timing_select,
  input wire auto_ack_enable,
  input wire [6:0] own_address_register,
  input wire shift_write,
  input wire [7:0] shift_wdata,
  output reg [7:0] bus_shift_register,
  output reg stop_detected_flag,
  output reg bus_controller_irq,
  output reg wait_active,
  output reg address_match,
  output reg extension_code
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SDA_LOW = 4'b0010;
  localparam [3:0] ST_SCL_REL = 4'b0100;
  localparam [3:0] ST_SDA_REL = 4'b1000;

  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;
  wire start_det;
  wire stop_det;

  line_sync u_scl_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .line_in(serial_clock_pin_in),
    .level(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  line_sync u_sda_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .line_in(serial_data_pin_in),
    .level(sda_lvl),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  bus_condition u_cond (
    .scl_level(scl_lvl),
    .sda_rise(sda_rise),
    .sda_fall(sda_fall),
    .start_seen(start_det),
    .stop_seen(stop_det)
  );

  reg busy_r;
  reg active_r;
  reg addr_phase_r;
  reg first_fall_r;
  reg restart_r;
  reg slave_tx_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] tx_shift_r;
  reg stop_pend_r;
  reg [3:0] stop_st_r;
  reg [15:0] stop_cnt_r;
  reg gen_low_r;
  reg [15:0] gen_cnt_r;

  wire [3:0] edge_num = bit_cnt_r + 4'h1;
  wire byte_fall = scl_fall & active_r & ~first_fall_r;
  wire tx_now = master_mode ? transmit_mode : slave_tx_r;
  wire [3:0] data_wait_edge = wait_timing_select ? `SWC_EDGE_9 :
                              `SWC_EDGE_8;
  wire addr_ext = (bus_shift_register[7:4] == `SWC_EXT_LOW) |
                  (bus_shift_register[7:4] == `SWC_EXT_HIGH);
  wire addr_hit = bus_shift_register[7:1] == own_address_register;

  // Wakeup mode freezes the wait against every cancel action
  wire cancel_req = wait_release_bit | shift_write | communication_exit_bit |
                    (master_mode & (start_request_bit | stop_request_bit));
  wire cancel_ok = wait_active & ~wakeup_mode_bit & cancel_req;

  // Fall-edge event decode: interrupt and wait only on counted falls
  reg ev_irq;
  reg ev_wait;
  reg ev_drop;
  always @* begin
    ev_irq = 1'b0;
    ev_wait = 1'b0;
    ev_drop = 1'b0;
    if (byte_fall) begin
      if (addr_phase_r && master_mode) begin
        if (edge_num == `SWC_EDGE_9) begin
          ev_irq = 1'b1;
          ev_wait = 1'b1;
        end
      end else if (addr_phase_r) begin
        if (edge_num == `SWC_EDGE_8 && addr_ext) begin
          ev_irq = 1'b1;
          ev_wait = 1'b1;
        end else if (edge_num == `SWC_EDGE_9) begin
          if (address_match) begin
            ev_irq = 1'b1;
            ev_wait = 1'b1;
          end else if (!extension_code) begin
            ev_irq = restart_r;
            ev_drop = 1'b1;
          end
        end
      end else if (edge_num == data_wait_edge) begin
        ev_irq = 1'b1;
        ev_wait = 1'b1;
      end
    end
  end

  // Byte engine, wait state and status
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      active_r <= 1'b0;
      addr_phase_r <= 1'b0;
      first_fall_r <= 1'b0;
      restart_r <= 1'b0;
      slave_tx_r <= 1'b0;
      bit_cnt_r <= `SWC_RST_CNT;
      tx_shift_r <= `SWC_RST_BYTE;
      bus_shift_register <= `SWC_RST_BYTE;
      stop_detected_flag <= 1'b0;
      bus_controller_irq <= 1'b0;
      wait_active <= 1'b0;
      address_match <= 1'b0;
      extension_code <= 1'b0;
    end else if (!controller_enable_bit) begin
      busy_r <= 1'b0;
      active_r <= 1'b0;
      addr_phase_r <= 1'b0;
      wait_active <= 1'b0;
      bus_controller_irq <= 1'b0;
      bit_cnt_r <= `SWC_RST_CNT;
      tx_shift_r <= `SWC_RST_BYTE;
    end else begin
      bus_controller_irq <= ev_irq |
                            (stop_det & stop_interrupt_enable);
      // A stop in the same cycle as a start still leaves the flag set
      if (stop_det)
        stop_detected_flag <= 1'b1;
      else if (start_det)
        stop_detected_flag <= 1'b0;
      if (shift_write)
        tx_shift_r <= shift_wdata;
      if (scl_rise && active_r && bit_cnt_r < `SWC_EDGE_8)
        bus_shift_register <= {bus_shift_register[6:0], sda_lvl};
      if (start_det) begin
        restart_r <= busy_r;
        busy_r <= 1'b1;
        active_r <= 1'b1;
        addr_phase_r <= 1'b1;
        first_fall_r <= 1'b1;
        bit_cnt_r <= `SWC_RST_CNT;
        address_match <= 1'b0;
        extension_code <= 1'b0;
        wait_active <= 1'b0;
      end else if (stop_det) begin
        busy_r <= 1'b0;
        active_r <= 1'b0;
        addr_phase_r <= 1'b0;
        wait_active <= 1'b0;
      end else begin
        if (scl_fall && first_fall_r)
          first_fall_r <= 1'b0;
        if (byte_fall) begin
          if (bit_cnt_r < `SWC_EDGE_8 && !shift_write)
            tx_shift_r <= {tx_shift_r[6:0], 1'b1};
          if (edge_num == `SWC_EDGE_8 && addr_phase_r && !master_mode) begin
            address_match <= addr_hit;
            extension_code <= addr_ext;
            slave_tx_r <= bus_shift_register[0];
          end
          if (edge_num == `SWC_EDGE_9) begin
            bit_cnt_r <= `SWC_RST_CNT;
            addr_phase_r <= 1'b0;
          end else begin
            bit_cnt_r <= edge_num;
          end
        end
        if (ev_drop)
          active_r <= 1'b0;
        if (communication_exit_bit && !wakeup_mode_bit)
          active_r <= 1'b0;
        // Entry comes from the fall itself, so it outranks a cancel
        if (ev_wait)
          wait_active <= 1'b1;
        else if (cancel_ok)
          wait_active <= 1'b0;
      end
    end
  end

  // Master serial clock source; paused by waits and a pending stop
  wire gen_run = master_mode & busy_r & ~wait_active & ~stop_pend_r &
                 (stop_st_r == ST_IDLE);
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gen_low_r <= 1'b0;
      gen_cnt_r <= 16'h0000;
    end else if (!controller_enable_bit || !master_mode || !busy_r) begin
      gen_low_r <= 1'b0;
      gen_cnt_r <= 16'h0000;
    end else if (start_det) begin
      gen_low_r <= 1'b1;
      gen_cnt_r <= 16'h0000;
    end else if (gen_run && (gen_low_r || scl_lvl)) begin
      // High half counts only once the line is really high (stretching)
      if (gen_cnt_r >= SCL_HALF_CYC - 16'h0001) begin
        gen_cnt_r <= 16'h0000;
        gen_low_r <= ~gen_low_r;
      end else begin
        gen_cnt_r <= gen_cnt_r + 16'h0001;
      end
    end
  end

  // Stop generation: SDA low under SCL low, free SCL, then free SDA
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stop_pend_r <= 1'b0;
      stop_st_r <= ST_IDLE;
      stop_cnt_r <= 16'h0000;
    end else if (!controller_enable_bit) begin
      stop_pend_r <= 1'b0;
      stop_st_r <= ST_IDLE;
      stop_cnt_r <= 16'h0000;
    end else begin
      case (stop_st_r)
        ST_IDLE: begin
          stop_cnt_r <= 16'h0000;
          if (stop_request_bit && master_mode && !wakeup_mode_bit)
            stop_pend_r <= 1'b1;
          if (stop_pend_r && !scl_lvl && (gen_low_r || wait_active)) begin
            stop_pend_r <= 1'b0;
            stop_st_r <= ST_SDA_LOW;
          end
        end
        ST_SDA_LOW: begin
          if (stop_cnt_r >= STOP_HOLD_CYC - 16'h0001) begin
            stop_cnt_r <= 16'h0000;
            stop_st_r <= ST_SCL_REL;
          end else begin
            stop_cnt_r <= stop_cnt_r + 16'h0001;
          end
        end
        ST_SCL_REL: begin
          if (!scl_lvl)
            stop_cnt_r <= 16'h0000;
          else if (stop_cnt_r >= STOP_HOLD_CYC - 16'h0001)
            stop_st_r <= ST_SDA_REL;
          else
            stop_cnt_r <= stop_cnt_r + 16'h0001;
        end
        ST_SDA_REL: begin
          if (stop_det || !busy_r)
            stop_st_r <= ST_IDLE;
        end
        default: stop_st_r <= ST_IDLE;
      endcase
    end
  end

  // Pin drive; open-drain, so the output value is always low
  reg scl_oe_nxt;
  reg sda_oe_nxt;
  always @* begin
    scl_oe_nxt = 1'b0;
    sda_oe_nxt = 1'b0;
    if (controller_enable_bit) begin
      scl_oe_nxt = wait_active | (stop_st_r == ST_SDA_LOW) |
                   (gen_run & gen_low_r) |
                   (stop_pend_r & gen_low_r);
      if (stop_st_r == ST_SDA_LOW || stop_st_r == ST_SCL_REL)
        sda_oe_nxt = 1'b1;
      else if (active_r && bit_cnt_r == `SWC_EDGE_8) begin
        // ACK slot; with the 8-edge wait it starts at the 8th fall
        if (addr_phase_r && !master_mode)
          sda_oe_nxt = address_match |
                       (extension_code & auto_ack_enable);
        else if (!addr_phase_r && !tx_now)
          sda_oe_nxt = auto_ack_enable;
      end else if (active_r && bit_cnt_r < `SWC_EDGE_8 &&
                   ((addr_phase_r && master_mode) ||
                    (!addr_phase_r && tx_now)))
        sda_oe_nxt = ~tx_shift_r[7];
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe <= 1'b0;
    end else begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= scl_oe_nxt;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe <= sda_oe_nxt;
    end
  end
endmodule // i2c_stop_wait_control
`default_nettype wire

// ===== test/i2c_stop_wait_control_assertions.sv
// Assertion checker for the stop and wait control block
`timescale 1ns/1ps
`default_nettype none
module swc_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serial_clock_pin_oe,
  input wire logic controller_enable_bit,
  input wire logic master_mode,
  input wire logic stop_request_bit,
  input wire logic wait_release_bit,
  input wire logic communication_exit_bit,
  input wire logic wakeup_mode_bit,
  input wire logic shift_write,
  input wire logic bus_controller_irq,
  input wire logic wait_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire live = controller_enable_bit && wait_active;
  wire any = wait_release_bit || shift_write || communication_exit_bit;
  property p_hold; $rose(wait_active) |=> serial_clock_pin_oe; endproperty
  a_hold: assert property (p_hold) else $error("SCL not held");
  property p_keep;
    wait_active && $past(wait_active) |-> serial_clock_pin_oe;
  endproperty
  a_keep: assert property (p_keep) else $error("SCL let go");
  property p_free;
    !master_mode && $fell(wait_active) |=> !serial_clock_pin_oe;
  endproperty
  a_free: assert property (p_free) else $error("SCL kept");
  property p_rel;
    live && !wakeup_mode_bit && wait_release_bit |=> !wait_active;
  endproperty
  a_rel: assert property (p_rel) else $error("release lost");
  property p_exit;
    live && !wakeup_mode_bit && communication_exit_bit |=> !wait_active;
  endproperty
  a_exit: assert property (p_exit) else $error("exit lost");
  property p_wake; live && wakeup_mode_bit && any |=> wait_active; endproperty
  a_wake: assert property (p_wake) else $error("wakeup cancel");
  property p_en; !controller_enable_bit |=> !wait_active; endproperty
  a_en: assert property (p_en) else $error("wait while off");
  property p_slv;
    live && !master_mode && stop_request_bit && !any |=> wait_active;
  endproperty
  a_slv: assert property (p_slv) else $error("slave stop cancel");
  property p_irq; $rose(wait_active) |-> bus_controller_irq; endproperty
  a_irq: assert property (p_irq) else $error("wait w/o irq");
endmodule // swc_chk
bind i2c_stop_wait_control swc_chk u_swc_chk (.clk_sys, .reset_n,
  .serial_clock_pin_oe, .controller_enable_bit, .master_mode,
  .stop_request_bit, .wait_release_bit, .communication_exit_bit,
  .wakeup_mode_bit, .shift_write, .bus_controller_irq, .wait_active);
`default_nettype wire

// ===== test/bus_master_model.sv
// Behavioural bus master facing the block's serial pins
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  logic [3:0] bitn;
  logic hung;
  int n;
  initial begin
    scl_low = 0;
    sda_low = 0;
    bitn = 0;
    hung = 0;
  end
  // Stretched clock: wait for the line, bounded so a stuck slave shows
  task automatic rise_wait();
    scl_low = 0;
    n = 0;
    while (!scl && n < 4000) begin
      #40;
      n++;
    end
    if (!scl) hung = 1;
  endtask
  // Works from idle and, as a restart, from mid-transfer
  task automatic start();
    sda_low = 0;
    #120 rise_wait();
    #160 sda_low = 1;
    #160 scl_low = 1;
    bitn = 0;
  endtask
  task automatic stop();
    sda_low = 1;
    #120 rise_wait();
    #160 sda_low = 0;
    #160;
  endtask
  task automatic xfer(input logic [7:0] d, output logic ack);
    for (int i = 1; i <= 9; i++) begin
      #120 sda_low = (i < 9) ? !d[8-i] : 1'b0;
      #120 rise_wait();
      if (i == 9) ack = sda;
      #80 scl_low = 1;
      bitn = i[3:0];
    end
  endtask
endmodule // bus_master_model
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the stop and wait control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys, reset_n, m_scl, m_sda, scl_oe, sda_oe, scl_out, sda_out;
  logic irq, wt, am, ec, flag, ack, en, stt, wrel, lrel, wup, sie;
  logic wtim, acke, sw, spt, mst, tx;
  logic [7:0] sr, d, wdata;
  logic [6:0] own;
  int err_count, compares, irqs, seed, n0;
  wire scl_line = !(m_scl || (scl_oe && !scl_out));
  wire sda_line = !(m_sda || (sda_oe && !sda_out));
  bus_master_model pm (.scl(scl_line), .sda(sda_line), .scl_low(m_scl),
    .sda_low(m_sda));
  i2c_stop_wait_control #(.STOP_HOLD_CYC(16'h0004),
    .SCL_HALF_CYC(16'h0004)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .serial_clock_pin_in(scl_line), .serial_clock_pin_out(scl_out),
    .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda_line),
    .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe),
    .controller_enable_bit(en), .master_mode(mst), .transmit_mode(tx),
    .stop_request_bit(spt), .start_request_bit(stt),
    .wait_release_bit(wrel), .communication_exit_bit(lrel),
    .wakeup_mode_bit(wup), .stop_interrupt_enable(sie),
    .wait_timing_select(wtim), .auto_ack_enable(acke),
    .own_address_register(own), .shift_write(sw), .shift_wdata(wdata),
    .bus_shift_register(sr), .stop_detected_flag(flag),
    .bus_controller_irq(irq), .wait_active(wt), .address_match(am),
    .extension_code(ec));
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = !clk_sys;
  end
  always @(posedge clk_sys) if (irq === 1'b1) irqs++;
  task automatic results();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cancel(input int k);
    @(posedge clk_sys) #1;
    case (k)
      0: wrel = 1;
      1: {sw, wdata} = {1'b1, 8'hFF};
      2: lrel = 1;
      default: spt = 1;
    endcase
    @(posedge clk_sys) #1;
    {wrel, sw, lrel, spt} = 4'h0;
  endtask
  task automatic waitw(input logic [3:0] e);
    for (int i = 0; i < 300 && wt !== 1'b1; i++) @(posedge clk_sys);
    #1 if (wt !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, wt, 1'b1);
      results();
    end
    chk(pm.bitn, e);
  endtask
  // One byte that must stall at edge e, then one cancel of kind k
  task automatic byte_w(input logic [7:0] v, input logic [3:0] e, int k);
    n0 = irqs;
    fork
      pm.xfer(v, ack);
      begin
        waitw(e);
        cancel(k);
      end
    join
    chk(8'(irqs - n0), 8'h01);
  endtask
  initial begin
    {reset_n, stt, wrel, lrel, wup, sw, spt, mst, tx, wtim} = 10'h000;
    // Auto-ACK stays set before any wait is released
    {en, sie, acke, wdata, irqs, err_count, compares} = {3'h7, 8'h00, 96'h0};
    seed = 32'h9c976b18;
    own = {2'h1, 5'($random(seed))};
    repeat (20) @(posedge clk_sys);
    #1 reset_n = 1;
    chk(sr, 8'hFF);
    chk({flag, irq, wt, am, ec}, 8'h00);
    $display("reset test done");
    pm.start();
    byte_w({own, 1'b0}, 4'h9, 0);
    chk({am, ack}, 8'h02);
    for (int j = 0; j < 2; j++) begin
      wtim = j[0];
      d = 8'($random(seed));
      byte_w(d, 4'h8 + j[3:0], j);
      chk(sr, d);
      chk(ack, 1'b0);
    end
    $display("address and data test done");
    d = 8'($random(seed));
    fork
      pm.xfer(d, ack);
      begin
        waitw(4'h9);
        wup = 1;
        cancel(0);
        repeat (4) @(posedge clk_sys);
        #1 chk(wt, 1'b1);
        wup = 0;
        cancel(2);
        repeat (2) @(posedge clk_sys);
        #1 chk(wt, 1'b0);
      end
    join
    n0 = irqs;
    pm.stop();
    chk({flag, 7'(irqs - n0)}, 8'h81);
    $display("wakeup, exit and stop test done");
    pm.start();
    byte_w({own, 1'b0}, 4'h9, 0);
    pm.start();
    n0 = irqs;
    pm.xfer({own ^ 7'h08, 1'b0}, ack);
    // The 9th fall reaches the block through the synchroniser first
    repeat (6) @(posedge clk_sys);
    #1 chk({wt, 7'(irqs - n0)}, 8'h01);
    sie = 0;
    pm.stop();
    pm.start();
    n0 = irqs;
    pm.xfer({own ^ 7'h08, 1'b1}, ack);
    pm.stop();
    chk({flag, ack, wt, 5'(irqs - n0)}, 8'hC0);
    $display("mismatch test done");
    pm.start();
    fork
      pm.xfer(8'h00, ack);
      begin
        waitw(4'h8);
        cancel(3);
        repeat (2) @(posedge clk_sys);
        #1 chk(wt, 1'b1);
        en = 0;
        repeat (3) @(posedge clk_sys);
        #1 chk({wt, scl_oe}, 8'h00);
        en = 1;
      end
    join
    pm.stop();
    chk(pm.hung, 1'b0);
    $display("extension and disable test done");
    results();
  end
endmodule // tb
`default_nettype wire
